// file: src/timer_output_flop_control_defines.svh
`ifndef TIMER_OUTPUT_FLOP_CONTROL_DEFINES_SVH
`define TIMER_OUTPUT_FLOP_CONTROL_DEFINES_SVH

// Register indices as printed; byte address is four times the index
`define FLOP_SOURCE_SEL_LO_IDX 32'h00800220
`define FLOP_SOURCE_SEL_HI_IDX 32'h00800223
`define FLOP_WRITE_GUARD_LO_IDX 32'h00800224
`define FLOP_FORCE_VALUE_LO_IDX 32'h00800226
`define FLOP_WRITE_GUARD_HI_IDX 32'h00800229
`define FLOP_FORCE_VALUE_HI_IDX 32'h0080022b

// Reset values
`define FLOP_SOURCE_SEL_LO_RST 16'h0000
`define FLOP_SOURCE_SEL_HI_RST 8'h00
`define FLOP_WRITE_GUARD_LO_RST 16'h0000
`define FLOP_WRITE_GUARD_HI_RST 8'h00
`define FLOP_OUT_RST 21'h000000

// Implemented bits; the rest read as zero and ignore writes
`define FLOP_SOURCE_SEL_LO_MASK 16'h1fff
`define FLOP_GUARD_HI_MASK 8'h1f

// Field positions in flop_source_sel_lo (bit 0 is the least significant)
`define SEL_FLOP6_BIT 0
`define SEL_FLOP7_BIT 1
`define SEL_FLOP8_LSB 2
`define SEL_FLOP9_LSB 4
`define SEL_FLOP10_LSB 6
`define SEL_FLOP11_BIT 8
`define SEL_FLOP12_BIT 9
`define SEL_FLOP13_BIT 10
`define SEL_FLOP14_BIT 11
`define SEL_FLOP15_BIT 12

// Field positions in flop_source_sel_hi
`define SEL_FLOP16_LSB 0
`define SEL_FLOP17_LSB 2
`define SEL_FLOP18_LSB 4
`define SEL_FLOP19_LSB 6

// Flop counts
`define FLOP_COUNT 21
`define FLOP_LO_COUNT 16
`define OUT_TIMER_COUNT 11
`define IO_TIMER_COUNT 10

`endif

// file: src/timer_output_flop_control_pkg.sv
package timer_output_flop_control_pkg;

  typedef enum logic [2:0] {
    MODE_SINGLE_SHOT,
    MODE_DELAYED_SINGLE_SHOT,
    MODE_CONTINUOUS,
    MODE_PWM,
    MODE_MEASURE_CLEAR,
    MODE_MEASURE_FREE_RUN,
    MODE_NOISE_PROCESSING
  } timer_mode_t;

  // One timer's status toward the flop unit; start and underflow are pulses
  typedef struct packed {
    timer_mode_t mode;
    logic start;
    logic underflow;
  } timer_evt_t;

  // Output event bus source selection, set by the event bus selectors
  typedef struct packed {
    logic [1:0] line3;
    logic line2;
    logic line1;
    logic line0;
  } bus_sel_t;

endpackage

// file: src/timer_output_flop_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_output_flop_control_defines.svh"

// Contract
// - Output-mode timers toggle flop on enable and underflow
// - Delayed single-shot and input modes: underflow only
// - Measurement timers never drive flop events
// - Flop events separate from underflow-only bus events
// - Flops 15-11 single-bit selectors pick io timer or bus
// - Flops 10, 9: timer, bus0 or bus1
// - Flop 8: timer, bus0, bus1 or bus2
// - Flop 7 bus0, flop 6 bus1 alternatives
// - Flops 19-17: io timer, bus0 or bus1
// - Flop 16: io timer5, bus0, bus1, bus3
// - Unassigned bits read zero, ignore writes
// - Guard bit set blocks software data write
// - Data write skips guarded flops only
// - Written level forces the flop output
// - Guard bits mapped per flop number
// - Data bits mapped per flop number
// - Bus lines carry selected timer underflow
module timer_output_flop_control (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Timers
  input wire timer_output_flop_control_pkg::timer_evt_t [`OUT_TIMER_COUNT-1:0] out_timer,
  input wire timer_output_flop_control_pkg::timer_evt_t [`IO_TIMER_COUNT-1:0] io_timer,
  input wire timer_output_flop_control_pkg::bus_sel_t bus_sel,
  // Flop outputs
  output logic [`FLOP_COUNT-1:0] flop_out
);

  logic [15:0] sel_lo_q;
  logic [7:0] sel_hi_q;
  logic [15:0] guard_lo_q;
  logic [7:0] guard_hi_q;
  logic [`FLOP_COUNT-1:0] flop_q;
  logic [31:0] hrdata_q;
  logic wr_pend_q;
  logic [31:0] wr_addr_q;
  logic [`FLOP_COUNT-1:0] guard;
  logic [`OUT_TIMER_COUNT-1:0] out_fe;
  logic [`IO_TIMER_COUNT-1:0] io_fe;
  logic [3:0] bus;
  logic [`FLOP_COUNT-1:0] ev;
  logic [`FLOP_COUNT-1:0] sw_en;
  logic [`FLOP_COUNT-1:0] sw_val;
  logic addr_ok;
  logic rd_ok;
  logic [31:0] rd_d;

  // Per-bit reset levels of the flops
  localparam logic [`FLOP_COUNT-1:0] FLOP_RST = `FLOP_OUT_RST;

  // Event toward the flop: start only counts in the output modes
  function automatic logic flop_event(input timer_output_flop_control_pkg::timer_evt_t t);
    logic on_start;
    on_start = 1'b0;
    case (t.mode)
      timer_output_flop_control_pkg::MODE_SINGLE_SHOT,
      timer_output_flop_control_pkg::MODE_CONTINUOUS,
      timer_output_flop_control_pkg::MODE_PWM: on_start = 1'b1;
      default: on_start = 1'b0;
    endcase
    return t.underflow | (t.start & on_start);
  endfunction

  // Two-bit field of the form 0X: timer, 10: bus a, 11: bus b
  function automatic logic pick_0x(input logic [1:0] f, input logic tmr,
                                   input logic ba, input logic bb);
    logic r;
    r = tmr;
    if (f == 2'b10) begin
      r = ba;
    end else if (f == 2'b11) begin
      r = bb;
    end
    return r;
  endfunction

  // Four-way field: 00 timer, 01 a, 10 b, 11 c
  function automatic logic pick_4(input logic [1:0] f, input logic tmr,
                                  input logic ba, input logic bb, input logic bc);
    logic r;
    r = tmr;
    case (f)
      2'b01: r = ba;
      2'b10: r = bb;
      2'b11: r = bc;
      default: r = tmr;
    endcase
    return r;
  endfunction

  // Per-timer flop events; measurement timers have no port here at all
  genvar g;
  generate
    for (g = 0; g < `OUT_TIMER_COUNT; g = g + 1) begin : g_out_fe
      assign out_fe[g] = flop_event(out_timer[g]);
    end
    for (g = 0; g < `IO_TIMER_COUNT; g = g + 1) begin : g_io_fe
      assign io_fe[g] = flop_event(io_timer[g]);
    end
  endgenerate

  // Output event bus lines take underflows only
  always_comb begin
    bus[0] = bus_sel.line0 ? io_timer[0].underflow : out_timer[6].underflow;
    bus[1] = bus_sel.line1 ? io_timer[1].underflow : out_timer[7].underflow;
    bus[2] = bus_sel.line2 ? io_timer[2].underflow : out_timer[9].underflow;
    case (bus_sel.line3)
      2'b00: bus[3] = out_timer[8].underflow;
      2'b01: bus[3] = io_timer[3].underflow;
      2'b10: bus[3] = io_timer[4].underflow;
      default: bus[3] = io_timer[8].underflow;
    endcase
  end

  // Source selection per flop
  always_comb begin
    ev[5:0] = out_fe[5:0];
    ev[6] = sel_lo_q[`SEL_FLOP6_BIT] ? bus[1] : out_fe[6];
    ev[7] = sel_lo_q[`SEL_FLOP7_BIT] ? bus[0] : out_fe[7];
    ev[8] = pick_4(sel_lo_q[`SEL_FLOP8_LSB +: 2], out_fe[8], bus[0], bus[1], bus[2]);
    ev[9] = pick_0x(sel_lo_q[`SEL_FLOP9_LSB +: 2], out_fe[9], bus[0], bus[1]);
    ev[10] = pick_0x(sel_lo_q[`SEL_FLOP10_LSB +: 2], out_fe[10], bus[0], bus[1]);
    ev[11] = sel_lo_q[`SEL_FLOP11_BIT] ? bus[1] : io_fe[0];
    ev[12] = sel_lo_q[`SEL_FLOP12_BIT] ? bus[2] : io_fe[1];
    ev[13] = sel_lo_q[`SEL_FLOP13_BIT] ? bus[3] : io_fe[2];
    ev[14] = sel_lo_q[`SEL_FLOP14_BIT] ? bus[0] : io_fe[3];
    ev[15] = sel_lo_q[`SEL_FLOP15_BIT] ? bus[0] : io_fe[4];
    ev[16] = pick_4(sel_hi_q[`SEL_FLOP16_LSB +: 2], io_fe[5], bus[0], bus[1], bus[3]);
    ev[17] = pick_0x(sel_hi_q[`SEL_FLOP17_LSB +: 2], io_fe[6], bus[0], bus[1]);
    ev[18] = pick_0x(sel_hi_q[`SEL_FLOP18_LSB +: 2], io_fe[7], bus[0], bus[1]);
    ev[19] = pick_0x(sel_hi_q[`SEL_FLOP19_LSB +: 2], io_fe[8], bus[0], bus[1]);
    ev[20] = io_fe[9];
  end

  // Bus decode
  assign guard = {guard_hi_q[4:0], guard_lo_q};
  assign addr_ok = hsel & hready & htrans[1];
  assign rd_ok = addr_ok & ~hwrite;

  always_comb begin
    rd_d = 32'h00000000;
    if (haddr == {`FLOP_SOURCE_SEL_LO_IDX << 2}) begin
      rd_d = {16'h0000, sel_lo_q};
    end else if (haddr == {`FLOP_SOURCE_SEL_HI_IDX << 2}) begin
      rd_d = {24'h000000, sel_hi_q};
    end else if (haddr == {`FLOP_WRITE_GUARD_LO_IDX << 2}) begin
      rd_d = {16'h0000, guard_lo_q};
    end else if (haddr == {`FLOP_FORCE_VALUE_LO_IDX << 2}) begin
      rd_d = {16'h0000, flop_q[15:0]};
    end else if (haddr == {`FLOP_WRITE_GUARD_HI_IDX << 2}) begin
      rd_d = {24'h000000, guard_hi_q};
    end else if (haddr == {`FLOP_FORCE_VALUE_HI_IDX << 2}) begin
      rd_d = {27'h0000000, flop_q[20:16]};
    end
  end

  // Software force of the flops in the write data phase
  always_comb begin
    sw_en = '0;
    sw_val = '0;
    if (wr_pend_q && wr_addr_q == {`FLOP_FORCE_VALUE_LO_IDX << 2}) begin
      sw_en[15:0] = ~guard[15:0];
      sw_val[15:0] = hwdata[15:0];
    end else if (wr_pend_q && wr_addr_q == {`FLOP_FORCE_VALUE_HI_IDX << 2}) begin
      sw_en[20:16] = ~guard[20:16];
      sw_val[20:16] = hwdata[4:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h00000000;
    end else begin
      wr_pend_q <= addr_ok & hwrite;
      wr_addr_q <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_ok) begin
      hrdata_q <= rd_d;
    end
  end

  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_lo_q <= `FLOP_SOURCE_SEL_LO_RST;
      sel_hi_q <= `FLOP_SOURCE_SEL_HI_RST;
      guard_lo_q <= `FLOP_WRITE_GUARD_LO_RST;
      guard_hi_q <= `FLOP_WRITE_GUARD_HI_RST;
    end else if (wr_pend_q) begin
      if (wr_addr_q == {`FLOP_SOURCE_SEL_LO_IDX << 2}) begin
        sel_lo_q <= hwdata[15:0] & `FLOP_SOURCE_SEL_LO_MASK;
      end else if (wr_addr_q == {`FLOP_SOURCE_SEL_HI_IDX << 2}) begin
        sel_hi_q <= hwdata[7:0];
      end else if (wr_addr_q == {`FLOP_WRITE_GUARD_LO_IDX << 2}) begin
        guard_lo_q <= hwdata[15:0];
      end else if (wr_addr_q == {`FLOP_WRITE_GUARD_HI_IDX << 2}) begin
        guard_hi_q <= hwdata[7:0] & `FLOP_GUARD_HI_MASK;
      end
    end
  end

  // The flops themselves
  generate
    for (g = 0; g < `FLOP_COUNT; g = g + 1) begin : g_flop
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          flop_q[g] <= FLOP_RST[g];
        end else if (sw_en[g]) begin
          flop_q[g] <= sw_val[g];
        end else if (ev[g]) begin
          flop_q[g] <= ~flop_q[g];
        end
      end
    end
  endgenerate

  assign flop_out = flop_q;
  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule
`default_nettype wire

// file: tb/timer_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module timer_far_side (
  // Requests from the bench
  input wire timer_output_flop_control_pkg::timer_mode_t mode,
  input wire logic [10:0] out_uf,
  input wire logic [10:0] out_st,
  input wire logic [9:0] io_uf,
  input wire logic [9:0] io_st,
  // Toward the flop unit
  output var timer_output_flop_control_pkg::timer_evt_t [10:0] out_timer,
  output var timer_output_flop_control_pkg::timer_evt_t [9:0] io_timer
);
  // Every timer shares one mode; pulses last as long as the bench holds them
  always_comb begin
    for (int i = 0; i < 11; i++) out_timer[i] = {mode, out_st[i], out_uf[i]};
    for (int i = 0; i < 10; i++) io_timer[i] = {mode, io_st[i], io_uf[i]};
  end
endmodule
`default_nettype wire

// file: tb/timer_flop_checker.sv
`timescale 1ns/1ps
`default_nettype none
module timer_flop_checker (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Timers and flops
  input wire timer_output_flop_control_pkg::timer_evt_t [10:0] out_timer,
  input wire timer_output_flop_control_pkg::timer_evt_t [9:0] io_timer,
  input wire logic [20:0] flop_out
);
  logic wr_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr_q <= 1'b0;
    else wr_q <= hsel & hready & htrans[1] & hwrite;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // No software write lands in this cycle
  sequence s_quiet;
    !wr_q;
  endsequence
  sequence s_out_start(int k);
    out_timer[k].start && !out_timer[k].underflow;
  endsequence
  a_ready_always: assert property (hreadyout) else $error("hreadyout low");
  a_okay_resp: assert property (!hresp) else $error("hresp not okay");
  a_rdata_upper: assert property (hrdata[31:16] == 16'h0) else $error("hrdata upper set");
  a_flop0_uflow: assert property (out_timer[0].underflow ##0 s_quiet |=>
    flop_out[0] != $past(flop_out[0])) else $error("flop0 no toggle");
  a_start_toggle: assert property (s_out_start(1) ##0 s_quiet ##0
    out_timer[1].mode inside {3'h0, 3'h2, 3'h3} |=> $changed(flop_out[1]))
    else $error("flop1 no toggle");
  a_delay_ignored: assert property (s_out_start(2) ##0 s_quiet ##0
    out_timer[2].mode == 3'h1 |=> $stable(flop_out[2])) else $error("flop2 toggled");
  a_flop_hold: assert property (!out_timer[3].underflow && !out_timer[3].start && !wr_q
    |=> $stable(flop_out[3])) else $error("flop3 moved");
  a_flop20_io9: assert property (io_timer[9].underflow && !wr_q |=>
    flop_out[20] != $past(flop_out[20])) else $error("flop20 no toggle");
endmodule
bind timer_output_flop_control timer_flop_checker u_timer_flop_checker (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .out_timer(out_timer),
  .io_timer(io_timer), .flop_out(flop_out));
`default_nettype wire

// file: tb/timer_output_flop_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_output_flop_control_defines.svh"
module timer_output_flop_control_tb;
  logic [31:0] regs [6] = '{`FLOP_SOURCE_SEL_LO_IDX * 4, `FLOP_SOURCE_SEL_HI_IDX * 4,
    `FLOP_WRITE_GUARD_LO_IDX * 4, `FLOP_FORCE_VALUE_LO_IDX * 4,
    `FLOP_WRITE_GUARD_HI_IDX * 4, `FLOP_FORCE_VALUE_HI_IDX * 4};
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [20:0] flop_out, exp_ff = 21'h0;
  logic [10:0] out_uf = 11'h0, out_st = 11'h0;
  logic [9:0] io_uf = 10'h0, io_st = 10'h0;
  timer_output_flop_control_pkg::timer_mode_t mode = timer_output_flop_control_pkg::MODE_PWM;
  timer_output_flop_control_pkg::bus_sel_t bus_sel = 5'h00;
  timer_output_flop_control_pkg::timer_evt_t [10:0] out_timer;
  timer_output_flop_control_pkg::timer_evt_t [9:0] io_timer;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  always #12.5 hclk = ~hclk;
  timer_output_flop_control u_timer_output_flop_control (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .out_timer(out_timer), .io_timer(io_timer), .bus_sel(bus_sel),
    .flop_out(flop_out));
  timer_far_side u_timer_far_side (.mode(mode), .out_uf(out_uf), .out_st(out_st),
    .io_uf(io_uf), .io_st(io_st), .out_timer(out_timer), .io_timer(io_timer));
  task automatic tally_and_finish();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One single transfer; called just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic pulse(input logic [10:0] ou, input logic [10:0] os, input logic [9:0] iu,
    input logic [9:0] is_, input logic [20:0] tog);
    out_uf <= ou;
    out_st <= os;
    io_uf <= iu;
    io_st <= is_;
    @(posedge hclk);
    out_uf <= 11'h0;
    out_st <= 11'h0;
    io_uf <= 10'h0;
    io_st <= 10'h0;
    @(posedge hclk);
    exp_ff = exp_ff ^ tog;
    chk("flop_out", {11'h0, flop_out}, {11'h0, exp_ff});
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, regs[i], 32'h0);
      chk("reset value", rd, 32'h0);
    end
    chk("hreadyout", {31'h0, hreadyout}, 32'h1);
    chk("hresp", {31'h0, hresp}, 32'h0);
    // Start toggles only in output modes; timers 1, 2 and io timer 0
    for (int m = 0; m < 7; m++) begin
      mode <= timer_output_flop_control_pkg::timer_mode_t'(m);
      pulse(11'h0, 11'h006, 10'h0, 10'h001, (m inside {0, 2, 3}) ? 21'h000806 : 21'h0);
    end
    pulse(11'h001, 11'h0, 10'h201, 10'h0, 21'h100801);
    bus(1'b1, regs[0], 32'hffff);
    bus(1'b0, regs[0], 32'h0);
    chk("sel_lo", rd, 32'h1fff);
    // Bus 1 carries timer 7 to flops 6, 9, 10 and 11
    pulse(11'h080, 11'h0, 10'h0, 10'h0, 21'h000e40);
    bus_sel.line3 <= 2'h1;
    bus(1'b1, regs[1], 32'h03);
    bus(1'b0, regs[1], 32'h0);
    chk("sel_hi", rd, 32'h03);
    pulse(11'h0, 11'h0, 10'h008, 10'h0, 21'h012000);
    bus(1'b1, regs[2], 32'h0008);
    bus(1'b1, regs[4], 32'hff);
    bus(1'b0, regs[4], 32'h0);
    chk("guard_hi", rd, 32'h1f);
    bus(1'b1, regs[3], 32'hffff);
    bus(1'b1, regs[5], 32'h0);
    exp_ff[15:0] = (exp_ff[15:0] & 16'h0008) | 16'hfff7;
    pulse(11'h0, 11'h0, 10'h0, 10'h0, 21'h0);
    bus(1'b0, regs[3], 32'h0);
    chk("force_lo", rd, {16'h0, exp_ff[15:0]});
    // Timer 0 underflows through both phases of a force write; the write wins
    out_uf <= 11'h001;
    bus(1'b1, regs[3], 32'h0000);
    out_uf <= 11'h000;
    exp_ff[15:0] = exp_ff[15:0] & 16'h0008;
    pulse(11'h0, 11'h0, 10'h0, 10'h0, 21'h0);
    bus(1'b1, regs[4], 32'h0);
    bus(1'b1, regs[5], 32'h0);
    exp_ff[20:16] = 5'h00;
    pulse(11'h0, 11'h0, 10'h0, 10'h0, 21'h0);
    bus(1'b0, 32'h02000884, 32'h0);
    chk("unmapped", rd, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
